/* rtl/sfd_pkg.sv */
// Purpose: types of the fixed-length serial command decoder
// Assumes: constants come from sfd_regs.svh
// Notes: phase codes are gray along idle, opcode, argument, sink
package sfd_pkg;

  typedef enum logic [1:0] {
    SFD_IDLE = 2'h0,
    SFD_OPCODE = 2'h1,
    SFD_ARG = 2'h3,
    SFD_SINK = 2'h2
  } sfd_phase_type;

  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] sckSync;
    logic [1:0] siSync;
    logic sckPrev;
    sfd_phase_type phase;
    logic [4:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] opcode;
    logic [7:0] txShift;
    logic so;
    logic soOeN;
    logic [1:0] bank;
    logic [15:0] ctrlOne;
    logic [15:0] ctrlTwo;
    logic [15:0] status;
    logic [5:0][15:0] ptr;
  } sfd_state_type;

endpackage : sfd_pkg

/* rtl/sfd_regs.svh */
// Purpose: constants of the fixed-length serial command decoder
// Assumes: included by bare name from the top module
// Notes: opcodes, bit positions, reset values and bit counts
// How it works
// RL1: one-byte commands arrive msb first as 11xxxxx0
// RL2: during one-byte commands SO is driven with junk while select low
// RL3: after any finished command the next one may follow in frame
// RL4: host must not end the frame before the eighth opcode bit
// RL5: one-byte commands ignore which register bank is selected
// RL6: four bank opcodes pick bank zero to three
// RL7: reset and system reset give bank zero; only those and the bank opcodes change it
// RL8: system reset opcode sets reset request, control two bit 4
// RL9: pause opcodes load control one bits 7:6 with 00 to 11
// RL10: packet down opcode sets control one bit 8
// RL11: dma opcodes write control one bits 5:2; halt clears run bit
// RL12: transmit opcode sets control one bit 1
// RL13: receive on and off opcodes set and clear control one bit 0
// RL14: irq on and off opcodes set and clear status bit 15
// RL15: bank read returns bank number in second byte, msb first
// RL16: bank read changes nothing and may be cut short
// RL17: pointer read returns low byte then high byte, SI ignored
// RL18: pointer reads change nothing and may be cut short
// RL19: host sends pointer low byte then high byte after opcode
// RL20: frame ending after sixteenth clock updates only the low byte
// RL21: pointer commands end at clock 24; SO junk during writes
// RL22: twelve pointer opcodes map to six pointers by opcode bits 4:2
// RL23: select high ends any command and releases SO
// RL24: SI taken on SCK rise, SO changed on SCK fall
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

`define SFD_OP_BANK0 8'hC0
`define SFD_OP_BANK1 8'hC2
`define SFD_OP_BANK2 8'hC4
`define SFD_OP_BANK3 8'hC6
`define SFD_OP_RBANK 8'hC8
`define SFD_OP_SYSRST 8'hCA
`define SFD_OP_PKTDN 8'hCC
`define SFD_OP_DMAHALT 8'hD2
`define SFD_OP_TXREQ 8'hD4
`define SFD_OP_DMASUM 8'hD8
`define SFD_OP_DMASUMS 8'hDA
`define SFD_OP_DMAMOV 8'hDC
`define SFD_OP_DMAMOVS 8'hDE
`define SFD_OP_PAUSE0 8'hE0
`define SFD_OP_PAUSE1 8'hE2
`define SFD_OP_PAUSE2 8'hE4
`define SFD_OP_PAUSE3 8'hE6
`define SFD_OP_RXON 8'hE8
`define SFD_OP_RXOFF 8'hEA
`define SFD_OP_IRQON 8'hEC
`define SFD_OP_IRQOFF 8'hEE
`define SFD_PTR_PREFIX 3'h3
`define SFD_PTR_COUNT 3'h6

`define SFD_C1_RX_ON 0
`define SFD_C1_TXREQ 1
`define SFD_C1_DMA_LSB 2
`define SFD_C1_DMA_RUN 5
`define SFD_C1_PAUSE_LSB 6
`define SFD_C1_PKTDN 8
`define SFD_C2_RSTREQ 4
`define SFD_ST_IRQEN 15

`define SFD_C1_RESET 16'h0000
`define SFD_C2_RESET 16'h0000
`define SFD_ST_RESET 16'h0000
`define SFD_PTR_RESET 16'h0000
`define SFD_BANK_RESET 2'h0

`define SFD_BYTE_END 5'h07
`define SFD_WORD_END 5'h0F
`define SFD_PTR_END 5'h17

`endif

/* rtl/sfd_spi_fixed_cmd.sv */
// Purpose: decode one, two and three byte serial commands
// Assumes: pins asynchronous to ref_clk; SCK well below ref_clk / 8
// Notes: variable length opcodes are swallowed until select rises
// Notes: undefined one-byte codes are dropped and the frame carries on
`timescale 1ns/1ps
`include "sfd_regs.svh"

module sfd_spi_fixed_cmd (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soOeN,
  input wire logic txDone,
  input wire logic packetDownDone,
  input wire logic dmaDone,
  input wire logic resetDone,
  output logic [1:0] bankSelect,
  output logic [15:0] controlRegisterOne,
  output logic [15:0] controlRegisterTwo,
  output logic [15:0] mainStatusRegister,
  output logic [15:0] generalReadPointer,
  output logic [15:0] receiveReadPointer,
  output logic [15:0] userAreaReadPointer,
  output logic [15:0] generalWritePointer,
  output logic [15:0] receiveWritePointer,
  output logic [15:0] userAreaWritePointer
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfd_pkg::sfd_state_type s;
  sfd_pkg::sfd_state_type n;

  logic csLow;
  logic sckRise;
  logic sckFall;
  logic siBit;
  logic [7:0] rxNew;
  logic [2:0] ptrIdx;
  logic isRead;
  logic isBankRead;
  logic isOneByte;
  logic isPtrCmd;

  // ----------------------------------------------------------------
  // pin view after the two-stage synchronisers
  // ----------------------------------------------------------------
  assign csLow = ~s.csSync[1];
  assign siBit = s.siSync[1];
  assign sckRise = s.sckSync[1] & ~s.sckPrev;
  assign sckFall = ~s.sckSync[1] & s.sckPrev;
  assign rxNew = {s.rxShift[6:0], siBit};
  assign ptrIdx = s.opcode[4:2];
  assign isRead = s.opcode[1];

  // ----------------------------------------------------------------
  // opcode classes, judged on the byte just completed
  // ----------------------------------------------------------------
  // one-byte family is 11xxxxx0; the bank read shares that shape [RL1]
  assign isBankRead = rxNew == `SFD_OP_RBANK;
  assign isOneByte = rxNew[7:6] == 2'h3 && !rxNew[0];
  // pointer family is 011xxxd0; slots 6 and 7 are not pointers [RL22]
  assign isPtrCmd = rxNew[7:5] == `SFD_PTR_PREFIX && !rxNew[0]
                    && rxNew[4:2] < `SFD_PTR_COUNT;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // first stage feeds only the second
    n.csSync = {s.csSync[0], csN};
    n.sckSync = {s.sckSync[0], sck};
    n.siSync = {s.siSync[0], si};
    n.sckPrev = s.sckSync[1];

    // engine completion clears; command sets below override them
    // so a done pulse meeting its own set opcode loses to the set
    if (txDone) begin
      n.ctrlOne[`SFD_C1_TXREQ] = 1'b0;
    end
    if (packetDownDone) begin
      n.ctrlOne[`SFD_C1_PKTDN] = 1'b0;
    end
    if (dmaDone) begin
      n.ctrlOne[`SFD_C1_DMA_RUN] = 1'b0;
    end
    if (resetDone) begin
      n.ctrlTwo[`SFD_C2_RSTREQ] = 1'b0;
    end

    if (!csLow) begin
      // frame over: abort whatever runs, release SO [RL23]
      n.phase = sfd_pkg::SFD_IDLE;
      n.bitCnt = 5'h00;
      n.soOeN = 1'b1;
      n.so = 1'b0;
      n.txShift = 8'h00;
    end else begin
      // drive SO for the whole frame [RL2] [RL21]
      n.soOeN = 1'b0;
      if (s.phase == sfd_pkg::SFD_IDLE) begin
        // first cycle of a frame: the count starts clean
        n.phase = sfd_pkg::SFD_OPCODE;
        n.bitCnt = 5'h00;
      end
      // SO moves on the fall, steady at the host's rise [RL24]
      if (sckFall) begin
        n.so = s.txShift[7];
        n.txShift = {s.txShift[6:0], 1'b0};
      end
      if (sckRise && s.phase != sfd_pkg::SFD_IDLE) begin
        // SI taken on the rise, msb first [RL24] [RL1]
        n.rxShift = rxNew;
        n.bitCnt = s.bitCnt + 5'h01;
        unique case (s.phase)
          sfd_pkg::SFD_OPCODE: begin
            if (s.bitCnt == `SFD_BYTE_END) begin
              n.opcode = rxNew;
              if (isBankRead) begin
                n.phase = sfd_pkg::SFD_ARG;
                n.txShift = {6'h00, s.bank}; // [RL15]
              end else if (isOneByte) begin
                // one-byte command, bank plays no part [RL1] [RL5]
                n.bitCnt = 5'h00; // [RL3]
                n.txShift = 8'h00;
                unique case (rxNew)
                  `SFD_OP_BANK0: begin
                    n.bank = 2'h0; // [RL6]
                  end
                  `SFD_OP_BANK1: begin
                    n.bank = 2'h1; // [RL6]
                  end
                  `SFD_OP_BANK2: begin
                    n.bank = 2'h2; // [RL6]
                  end
                  `SFD_OP_BANK3: begin
                    n.bank = 2'h3; // [RL6]
                  end
                  `SFD_OP_SYSRST: begin
                    n.ctrlTwo[`SFD_C2_RSTREQ] = 1'b1; // [RL8]
                    n.bank = `SFD_BANK_RESET; // [RL7]
                  end
                  // pause mode: off, one frame, periodic, final
                  `SFD_OP_PAUSE0: begin
                    n.ctrlOne[`SFD_C1_PAUSE_LSB +: 2] = 2'h0; // [RL9]
                  end
                  `SFD_OP_PAUSE1: begin
                    n.ctrlOne[`SFD_C1_PAUSE_LSB +: 2] = 2'h1; // [RL9]
                  end
                  `SFD_OP_PAUSE2: begin
                    n.ctrlOne[`SFD_C1_PAUSE_LSB +: 2] = 2'h2; // [RL9]
                  end
                  `SFD_OP_PAUSE3: begin
                    n.ctrlOne[`SFD_C1_PAUSE_LSB +: 2] = 2'h3; // [RL9]
                  end
                  `SFD_OP_PKTDN: begin
                    n.ctrlOne[`SFD_C1_PKTDN] = 1'b1; // [RL10]
                  end
                  `SFD_OP_DMAHALT: begin
                    n.ctrlOne[`SFD_C1_DMA_RUN] = 1'b0; // [RL11]
                  end
                  // all four bits written at once, never merged [RL11]
                  `SFD_OP_DMASUM: begin
                    n.ctrlOne[`SFD_C1_DMA_LSB +: 4] = 4'h8; // [RL11]
                  end
                  `SFD_OP_DMASUMS: begin
                    n.ctrlOne[`SFD_C1_DMA_LSB +: 4] = 4'hA; // [RL11]
                  end
                  `SFD_OP_DMAMOV: begin
                    n.ctrlOne[`SFD_C1_DMA_LSB +: 4] = 4'hC; // [RL11]
                  end
                  `SFD_OP_DMAMOVS: begin
                    n.ctrlOne[`SFD_C1_DMA_LSB +: 4] = 4'hE; // [RL11]
                  end
                  `SFD_OP_TXREQ: begin
                    n.ctrlOne[`SFD_C1_TXREQ] = 1'b1; // [RL12]
                  end
                  `SFD_OP_RXON: begin
                    n.ctrlOne[`SFD_C1_RX_ON] = 1'b1; // [RL13]
                  end
                  `SFD_OP_RXOFF: begin
                    n.ctrlOne[`SFD_C1_RX_ON] = 1'b0; // [RL13]
                  end
                  `SFD_OP_IRQON: begin
                    n.status[`SFD_ST_IRQEN] = 1'b1; // [RL14]
                  end
                  `SFD_OP_IRQOFF: begin
                    n.status[`SFD_ST_IRQEN] = 1'b0; // [RL14]
                  end
                  default: begin
                    // undefined 11xxxxx0 codes are dropped
                    n.bitCnt = 5'h00;
                  end
                endcase
              end else if (isPtrCmd) begin
                // pointer command, opcode bits 4:2 pick it [RL22]
                n.phase = sfd_pkg::SFD_ARG;
                if (rxNew[1]) begin
                  // low byte goes out first, on clocks 9 to 16
                  n.txShift = s.ptr[rxNew[4:2]][7:0]; // [RL17]
                end else begin
                  // write: SO carries zeros that the host ignores [RL21]
                  n.txShift = 8'h00;
                end
              end else begin
                // variable length: nothing may follow in this frame
                n.phase = sfd_pkg::SFD_SINK;
              end
            end
          end
          sfd_pkg::SFD_ARG: begin
            if (s.opcode == `SFD_OP_RBANK) begin
              // SO already holds the bank; only the count moves here
              if (s.bitCnt == `SFD_WORD_END) begin
                // read only, so a cut frame leaves no trace [RL16]
                n.phase = sfd_pkg::SFD_OPCODE;
                n.bitCnt = 5'h00;
                n.txShift = 8'h00;
              end
            end else if (isRead) begin
              // SI is ignored; the count moves and the high byte loads at clock 16 [RL17] [RL18]
              if (s.bitCnt == `SFD_WORD_END) begin
                n.txShift = s.ptr[ptrIdx][15:8]; // [RL17]
              end else if (s.bitCnt == `SFD_PTR_END) begin
                n.phase = sfd_pkg::SFD_OPCODE; // [RL21]
                n.bitCnt = 5'h00;
                n.txShift = 8'h00;
              end
            end else begin
              // low byte lands at clock 16, high byte kept till 24
              if (s.bitCnt == `SFD_WORD_END) begin
                n.ptr[ptrIdx][7:0] = rxNew; // [RL19] [RL20]
              end else if (s.bitCnt == `SFD_PTR_END) begin
                n.ptr[ptrIdx][15:8] = rxNew; // [RL19]
                n.phase = sfd_pkg::SFD_OPCODE; // [RL21]
                n.bitCnt = 5'h00;
              end
            end
          end
          sfd_pkg::SFD_SINK: begin
            // count held still so it cannot wrap into a match
            n.bitCnt = s.bitCnt;
          end
          sfd_pkg::SFD_IDLE: begin
            // unreachable: rises are not taken while idle
            n.bitCnt = s.bitCnt;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // select reads idle-high so reset never opens a frame
      s.csSync <= 2'h3;
      // clock idles low, so no false rise follows reset
      s.sckSync <= 2'h0;
      s.siSync <= 2'h0;
      s.sckPrev <= 1'b0;
      s.phase <= sfd_pkg::SFD_IDLE;
      s.bitCnt <= 5'h00;
      s.rxShift <= 8'h00;
      s.opcode <= 8'h00;
      s.txShift <= 8'h00;
      s.so <= 1'b0;
      s.soOeN <= 1'b1;
      s.bank <= `SFD_BANK_RESET; // [RL7]
      s.ctrlOne <= `SFD_C1_RESET;
      s.ctrlTwo <= `SFD_C2_RESET;
      s.status <= `SFD_ST_RESET;
      s.ptr <= {6{`SFD_PTR_RESET}};
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign so = s.so;
  assign soOeN = s.soOeN;
  assign bankSelect = s.bank;
  assign controlRegisterOne = s.ctrlOne;
  assign controlRegisterTwo = s.ctrlTwo;
  assign mainStatusRegister = s.status;
  // pointer slots follow opcode bits 4:2 [RL22]
  assign generalReadPointer = s.ptr[0];
  assign receiveReadPointer = s.ptr[1];
  assign userAreaReadPointer = s.ptr[2];
  assign generalWritePointer = s.ptr[3];
  assign receiveWritePointer = s.ptr[4];
  assign userAreaWritePointer = s.ptr[5];

endmodule : sfd_spi_fixed_cmd

/* test/sfd_host.sv */
// Purpose: host serial master driving select, clock and data
// Assumes: ref_clk 100 MHz; serial clock period 160 ns
// Notes: frames end on byte boundaries only
`timescale 1ns/1ps
module sfd_host (
  input wire logic ref_clk,
  input wire logic soWire,
  output logic csN,
  output logic sck,
  output logic si
);
  // -------------
  // serial master
  // -------------
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic frame_on;
    csN <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : frame_on
  // never mid-opcode, though argument bytes may be cut short
  task automatic frame_off;
    repeat (4) @(posedge ref_clk);
    csN <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge ref_clk);
  endtask : frame_off
  // msb first, so read just before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      repeat (8) @(posedge ref_clk);
      rx[i] = soWire;
      sck <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sck <= 1'b0;
    end
  endtask : xfer
endmodule : sfd_host

/* test/sfd_spi_fixed_cmd_bench.sv */
// Purpose: self-checking bench of the command decoder
// Assumes: host model drives the serial pins
// Notes: reference model kept in plain variables
`timescale 1ns/1ps
module sfd_spi_fixed_cmd_bench;
  // -----
  // bench
  // -----
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic txDone = 1'b0, packetDownDone = 1'b0, dmaDone = 1'b0;
  logic resetDone = 1'b0;
  logic csN, sck, si, so, soOeN, soWire;
  logic [1:0] bankSelect, mBank = 2'h0;
  logic [15:0] controlRegisterOne, controlRegisterTwo, mainStatusRegister;
  logic [15:0] generalReadPointer, receiveReadPointer, userAreaReadPointer;
  logic [15:0] generalWritePointer, receiveWritePointer, userAreaWritePointer;
  logic [5:0][15:0] dPtr;
  logic [15:0] mC1 = 16'h0000, mC2 = 16'h0000, mSt = 16'h0000, v;
  logic [15:0] mPtr [6] = '{default: 16'h0000};
  logic [7:0] r, lo, hi;
  logic [7:0] ops [16] = '{8'hCC, 8'hD4, 8'hD8, 8'hDA, 8'hD2, 8'hDC, 8'hDE,
    8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE, 8'hCA};
  int n_fail = 0, comparisons = 0, cyc = 0;
  integer seed = 62;
  // released pin shows the opposite of so, which release clears, so it reads high
  assign soWire = soOeN ? ~so : so;
  assign dPtr = {userAreaWritePointer, receiveWritePointer,
    generalWritePointer, userAreaReadPointer, receiveReadPointer,
    generalReadPointer};
  sfd_spi_fixed_cmd u_dut (.ref_clk, .sys_rst, .csN, .sck, .si, .so, .soOeN,
    .txDone, .packetDownDone, .dmaDone, .resetDone, .bankSelect,
    .controlRegisterOne, .controlRegisterTwo, .mainStatusRegister,
    .generalReadPointer, .receiveReadPointer, .userAreaReadPointer,
    .generalWritePointer, .receiveWritePointer, .userAreaWritePointer);
  sfd_host u_host (.ref_clk, .soWire, .csN, .sck, .si);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic cmp(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic chk_all;
    cmp("bank", 16'(mBank), 16'(bankSelect));
    cmp("ctrl one", mC1, controlRegisterOne);
    cmp("ctrl two", mC2, controlRegisterTwo);
    cmp("status", mSt, mainStatusRegister);
    for (int k = 0; k < 6; k++) cmp("pointer", mPtr[k], dPtr[k]);
  endtask : chk_all
  task automatic op1(input logic [7:0] op);
    u_host.xfer(op, r);
    case (op)
      8'hC0, 8'hC2, 8'hC4, 8'hC6: mBank = op[2:1];
      8'hCA: begin
        mC2[4] = 1'b1;
        mBank = 2'h0;
      end
      8'hCC: mC1[8] = 1'b1;
      8'hD2: mC1[5] = 1'b0;
      8'hD4: mC1[1] = 1'b1;
      8'hE0, 8'hE2, 8'hE4, 8'hE6: mC1[7:6] = op[2:1];
      8'hE8, 8'hEA: mC1[0] = ~op[1];
      8'hEC, 8'hEE: mSt[15] = ~op[1];
      default: mC1[5:2] = {1'b1, op[2:1], 1'b0};
    endcase
    chk_all;
  endtask : op1
  task automatic bank_rd;
    u_host.xfer(8'hC8, r);
    u_host.xfer(8'(cyc), r);
    cmp("bank read", 16'(mBank), 16'(r));
  endtask : bank_rd
  task automatic ptr_wr(input int k, input logic [15:0] d, input bit full);
    u_host.xfer({3'b011, 3'(k), 2'b00}, r);
    u_host.xfer(d[7:0], r);
    mPtr[k][7:0] = d[7:0];
    if (full) begin
      u_host.xfer(d[15:8], r);
      mPtr[k][15:8] = d[15:8];
    end
  endtask : ptr_wr
  // opcode-like filler on SI must be ignored
  task automatic ptr_rd(input int k);
    u_host.xfer({3'b011, 3'(k), 2'b10}, r);
    u_host.xfer(8'hEC, lo);
    u_host.xfer(8'hCA, hi);
    cmp("ptr low", 16'(mPtr[k][7:0]), 16'(lo));
    cmp("ptr high", 16'(mPtr[k][15:8]), 16'(hi));
  endtask : ptr_rd
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_all;
    u_host.frame_on;
    for (int b = 0; b < 4; b++) begin
      op1(8'hC0 + 8'(2 * b));
      bank_rd;
      foreach (ops[i]) op1(ops[i]);
    end
    u_host.frame_off;
    @(posedge ref_clk);
    txDone <= 1'b1;
    packetDownDone <= 1'b1;
    dmaDone <= 1'b1;
    resetDone <= 1'b1;
    @(posedge ref_clk);
    txDone <= 1'b0;
    packetDownDone <= 1'b0;
    dmaDone <= 1'b0;
    resetDone <= 1'b0;
    repeat (2) @(posedge ref_clk);
    mC1 = mC1 & 16'hFEDD;
    mC2 = 16'h0000;
    chk_all;
    for (int k = 0; k < 6; k++) begin
      v = 16'($random(seed));
      u_host.frame_on;
      ptr_wr(k, v, 1'b1);
      ptr_rd(k);
      bank_rd;
      u_host.frame_off;
      chk_all;
    end
    v = 16'($random(seed));
    u_host.frame_on;
    ptr_wr(4, v, 1'b0);
    u_host.frame_off;
    u_host.frame_on;
    u_host.xfer(8'h72, r);
    u_host.xfer(8'h00, r);
    cmp("ptr cut", 16'(mPtr[4][7:0]), 16'(r));
    u_host.frame_off;
    u_host.frame_on;
    u_host.xfer(8'hC8, r);
    u_host.frame_off;
    chk_all;
    // undefined one-byte code is dropped; pointer slot 6 sinks the frame
    u_host.frame_on;
    u_host.xfer(8'hD0, r);
    op1(8'hC2);
    u_host.xfer(8'h78, r);
    u_host.xfer(8'hC4, r);
    u_host.frame_off;
    chk_all;
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mBank = 2'h0;
    mC1 = 16'h0000;
    mC2 = 16'h0000;
    mSt = 16'h0000;
    foreach (mPtr[k]) mPtr[k] = 16'h0000;
    chk_all;
    give_verdict;
  end
endmodule : sfd_spi_fixed_cmd_bench

/* test/sfd_spi_fixed_cmd_chk.sv */
// Purpose: watch pins and register outputs of the command decoder
// Assumes: ref_clk 100 MHz, serial clock far slower
// Notes: bound into every decoder instance
`timescale 1ns/1ps
module sfd_spi_fixed_cmd_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic so,
  input wire logic soOeN,
  input wire logic txDone,
  input wire logic packetDownDone,
  input wire logic dmaDone,
  input wire logic [1:0] bankSelect,
  input wire logic [15:0] controlRegisterOne,
  input wire logic [15:0] controlRegisterTwo,
  input wire logic [15:0] mainStatusRegister,
  input wire logic [15:0] generalReadPointer,
  input wire logic [15:0] userAreaWritePointer
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_oe_on; !csN [*5] |-> !soOeN; endproperty
  a_oe_on: assert property (p_oe_on) else $error("so undriven");
  property p_oe_off; csN [*5] |-> soOeN; endproperty
  a_oe_off: assert property (p_oe_off) else $error("so driven");
  // sync delay is under six cycles, so a long high phase is quiet
  property p_so_calm; sck [*6] |-> $stable(so); endproperty
  a_so_calm: assert property (p_so_calm) else $error("so moved");
  property p_bank; $changed(bankSelect) |-> !csN; endproperty
  a_bank: assert property (p_bank) else $error("bank moved");
  property p_rst;
    $fell(sys_rst) |-> bankSelect == 2'h0 && controlRegisterOne == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_c2; (controlRegisterTwo & 16'hFFEF) == 16'h0000; endproperty
  a_c2: assert property (p_c2) else $error("ctrl two bits");
  property p_c1;
    $changed(controlRegisterOne) |->
      !csN || $past(txDone || packetDownDone || dmaDone);
  endproperty
  a_c1: assert property (p_c1) else $error("ctrl one moved");
  property p_st; $changed(mainStatusRegister) |-> !csN; endproperty
  a_st: assert property (p_st) else $error("status moved");
  property p_ptr;
    $changed({generalReadPointer, userAreaWritePointer}) |-> !csN;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer moved");
  c_frame: cover property ($fell(csN));
  c_bank: cover property ($changed(bankSelect));
  c_ptr: cover property ($changed(userAreaWritePointer));
endmodule : sfd_spi_fixed_cmd_chk

bind sfd_spi_fixed_cmd sfd_spi_fixed_cmd_chk u_chk (
  .ref_clk, .sys_rst, .csN, .sck, .so, .soOeN, .txDone, .packetDownDone,
  .dmaDone, .bankSelect, .controlRegisterOne, .controlRegisterTwo,
  .mainStatusRegister, .generalReadPointer, .userAreaWritePointer
);
